// [rtl/pia_arbiter.sv]
/*
 Processor-end priority arbiter with vectored interrupt entry, return,
 nesting and power traps. Assumes a memory with one-cycle interlocked
 answer on the mem_* port and an instruction sequencer on the cpu_* port.
*/
// Function
// - Five request lines, direct memory highest
// - Direct memory granted between bus cycles
// - No release inside read-modify-write
// - Priority held in status bits 7..5
// - Levels at or below priority refused
// - Nearest device on a line granted
// - Acknowledge highest level above priority
// - Devices interrupt on levels seven to four
// - Master sends command with vector address
// - Copy status and counter to temporaries
// - Load vector, push old, start routine
// - Return pops two words into counter, status
// - Higher request may nest after load
// - Vector is routine address then status
// - Power fail traps through 24
// - Power return traps through 24 again
// - Direct memory leaves processor state unchanged
// - Devices provide software request enables
// - Every master strobe answered by slave
`timescale 1ns/1ps
module pia_arbiter (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // System bus
   pia_bus_if.cpu           bus,
   // Instruction sequencer
   input  wire logic        cpu_bus_cycle_end,
   input  wire logic        cpu_rmw_active,
   input  wire logic        cpu_instr_end,
   input  wire logic        cpu_rti,
   input  wire logic        cpu_psw_write,
   input  wire logic [15:0] cpu_psw_wdata,
   output      logic        cpu_hold,
   output      logic        cpu_rti_done,
   // Power monitor
   input  wire logic        power_fail,
   // Memory
   output      logic        mem_strobe,
   output      logic        mem_write,
   output      logic [15:0] mem_addr,
   output      logic [15:0] mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   // Processor state
   output      logic [15:0] program_counter,
   output      logic [15:0] processor_status_word,
   output      logic [15:0] stack_pointer,
   output      logic        power_save_window
);
   typedef enum logic [3:0] {
      RUN, DM_GRANT, INT_GRANT, INT_WAIT, LOAD_PC, LOAD_PSW,
      PUSH_PSW, PUSH_PC, POP_PC, POP_PSW
   } pia_state_t;

   pia_state_t  state, next_state;
   logic [4:0]  grant, next_grant;
   logic [15:0] vector, next_vector;
   logic [15:0] tmp_pc, next_tmp_pc;
   logic [15:0] tmp_psw, next_tmp_psw;
   logic [15:0] next_pc, next_psw, next_sp;
   logic        power_prev, next_power_prev;
   logic        power_pending, next_power_pending;
   logic [31:0] save_cnt, next_save_cnt;
   logic [2:0]  prio;
   logic [2:0]  best_lvl;
   logic        best_valid;
   logic        intr_ack, next_intr_ack;

   assign prio = processor_status_word[pia_pkg::PRIO_HI:pia_pkg::PRIO_LO];

   // Highest pending level strictly above the processor priority.
   always_comb begin
      best_valid = 1'b0;
      best_lvl   = 3'h0;
      for (int i = 0; i < pia_pkg::NUM_INT_LEVELS; i++) begin
         if (bus.request[i] && (3'(i) + pia_pkg::LOWEST_INT_LVL > prio)) begin
            best_valid = 1'b1;
            best_lvl   = 3'(i) + pia_pkg::LOWEST_INT_LVL;
         end
      end
   end

   assign bus.grant    = grant;
   assign bus.intr_ack = intr_ack;
   assign bus.dm_rdata = mem_rdata;
   assign bus.dm_ack   = (state == DM_GRANT) && mem_ack;
   assign cpu_hold     = (state != RUN);

   always_comb begin
      next_state         = state;
      next_grant         = grant;
      next_vector        = vector;
      next_tmp_pc        = tmp_pc;
      next_tmp_psw       = tmp_psw;
      next_pc            = program_counter;
      next_psw           = processor_status_word;
      next_sp            = stack_pointer;
      next_power_prev    = power_fail;
      next_power_pending = power_pending;
      next_intr_ack      = 1'b0;
      next_save_cnt      = (save_cnt != 32'h0) ? save_cnt - 32'h1 : 32'h0;
      cpu_rti_done       = 1'b0;
      mem_strobe         = 1'b0;
      mem_write          = 1'b0;
      mem_addr           = 16'h0;
      mem_wdata          = 16'h0;
      if (power_fail != power_prev) begin
         next_power_pending = 1'b1;
      end
      unique case (state)
         RUN: begin
            if (cpu_psw_write) begin
               next_psw = cpu_psw_wdata;
            end
            // Direct memory wins at any bus-cycle end outside a read-modify-write.
            if (bus.request[4] && cpu_bus_cycle_end && !cpu_rmw_active) begin
               next_grant = 5'h10;
               next_state = DM_GRANT;
            end else if (cpu_instr_end && power_pending) begin
               // A fresh power edge in this very cycle stays pending for the next trap.
               next_power_pending = (power_fail != power_prev);
               next_vector        = pia_pkg::POWER_VECTOR;
               if (power_fail) begin
                  next_save_cnt = 32'(pia_pkg::POWER_SAVE_CYC);
               end
               next_tmp_pc  = program_counter;
               next_tmp_psw = processor_status_word;
               next_state   = LOAD_PC;
            end else if (cpu_instr_end && cpu_rti) begin
               next_state = POP_PC;
            end else if (cpu_instr_end && best_valid) begin
               next_grant = 5'(1) << (best_lvl - pia_pkg::LOWEST_INT_LVL);
               next_state = INT_GRANT;
            end
         end
         DM_GRANT: begin
            mem_strobe = bus.dm_strobe;
            mem_write  = bus.dm_write;
            mem_addr   = bus.dm_addr;
            mem_wdata  = bus.dm_wdata;
            if (bus.bus_busy) begin
               next_grant = 5'h0;
            end else if (grant == 5'h0) begin
               next_state = RUN;
            end
         end
         INT_GRANT: begin
            if (bus.bus_busy) begin
               next_grant = 5'h0;
               next_state = INT_WAIT;
            end
         end
         INT_WAIT: begin
            if (bus.intr_cmd) begin
               next_vector   = bus.intr_vector;
               next_intr_ack = 1'b1;
               next_tmp_pc   = program_counter;
               next_tmp_psw  = processor_status_word;
               next_state    = LOAD_PC;
            end else if (!bus.bus_busy) begin
               next_state = RUN;
            end
         end
         LOAD_PC: begin
            mem_strobe = 1'b1;
            mem_addr   = vector;
            if (mem_ack) begin
               next_pc    = mem_rdata;
               next_state = LOAD_PSW;
            end
         end
         LOAD_PSW: begin
            mem_strobe = 1'b1;
            mem_addr   = vector + pia_pkg::VECTOR_STEP;
            if (mem_ack) begin
               next_psw   = mem_rdata;
               next_state = PUSH_PSW;
            end
         end
         PUSH_PSW: begin
            mem_strobe = 1'b1;
            mem_write  = 1'b1;
            mem_addr   = stack_pointer - pia_pkg::STACK_STEP;
            mem_wdata  = tmp_psw;
            if (mem_ack) begin
               next_sp    = stack_pointer - pia_pkg::STACK_STEP;
               next_state = PUSH_PC;
            end
         end
         PUSH_PC: begin
            mem_strobe = 1'b1;
            mem_write  = 1'b1;
            mem_addr   = stack_pointer - pia_pkg::STACK_STEP;
            mem_wdata  = tmp_pc;
            if (mem_ack) begin
               next_sp    = stack_pointer - pia_pkg::STACK_STEP;
               next_state = RUN;
            end
         end
         POP_PC: begin
            mem_strobe = 1'b1;
            mem_addr   = stack_pointer;
            if (mem_ack) begin
               next_pc    = mem_rdata;
               next_sp    = stack_pointer + pia_pkg::STACK_STEP;
               next_state = POP_PSW;
            end
         end
         POP_PSW: begin
            mem_strobe = 1'b1;
            mem_addr   = stack_pointer;
            if (mem_ack) begin
               next_psw     = mem_rdata;
               next_sp      = stack_pointer + pia_pkg::STACK_STEP;
               cpu_rti_done = 1'b1;
               next_state   = RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state                 <= RUN;
         grant                 <= 5'h0;
         vector                <= 16'h0;
         tmp_pc                <= 16'h0;
         tmp_psw               <= 16'h0;
         program_counter       <= pia_pkg::PC_RESET;
         processor_status_word <= pia_pkg::PSW_RESET;
         stack_pointer         <= pia_pkg::SP_RESET;
         power_prev            <= 1'b0;
         power_pending         <= 1'b0;
         save_cnt              <= 32'h0;
         intr_ack              <= 1'b0;
      end else begin
         state                 <= next_state;
         grant                 <= next_grant;
         vector                <= next_vector;
         tmp_pc                <= next_tmp_pc;
         tmp_psw               <= next_tmp_psw;
         program_counter       <= next_pc;
         processor_status_word <= next_psw;
         stack_pointer         <= next_sp;
         power_prev            <= next_power_prev;
         power_pending         <= next_power_pending;
         save_cnt              <= next_save_cnt;
         intr_ack              <= next_intr_ack;
      end
   end

   assign power_save_window = (save_cnt != 32'h0);
endmodule

// [rtl/pia_bus_if.sv]
/*
 Interlocked system bus between the arbiter (processor end) and the
 requester end. Every request line has a grant; every master strobe is
 answered by dm_ack; every intr_cmd by intr_ack.
*/
`timescale 1ns/1ps
interface pia_bus_if;
   logic [4:0]  request;
   logic [4:0]  grant;
   logic        bus_busy;
   logic        intr_cmd;
   logic [15:0] intr_vector;
   logic        intr_ack;
   logic        dm_strobe;
   logic        dm_write;
   logic [15:0] dm_addr;
   logic [15:0] dm_wdata;
   logic [15:0] dm_rdata;
   logic        dm_ack;

   modport cpu (
      input  request,
      output grant,
      input  bus_busy,
      input  intr_cmd,
      input  intr_vector,
      output intr_ack,
      input  dm_strobe,
      input  dm_write,
      input  dm_addr,
      input  dm_wdata,
      output dm_rdata,
      output dm_ack
   );
   modport dev (
      output request,
      input  grant,
      output bus_busy,
      output intr_cmd,
      output intr_vector,
      input  intr_ack,
      output dm_strobe,
      output dm_write,
      output dm_addr,
      output dm_wdata,
      input  dm_rdata,
      input  dm_ack
   );
endinterface

// [rtl/pia_pkg.sv]
/*
 Shared constants and types for the priority interrupt arbiter and its
 requester end. Assumes a 16-bit word machine with a 3-bit priority field.
*/
package pia_pkg;
   localparam int          NUM_REQ_LINES   = 5;
   localparam int          NUM_INT_LEVELS  = 4;
   localparam int          WORD_W          = 16;
   localparam int          PRIO_HI         = 7;
   localparam int          PRIO_LO         = 5;
   localparam logic [2:0]  LOWEST_INT_LVL  = 3'h4;
   localparam logic [15:0] POWER_VECTOR    = 16'h0014;
   localparam logic [15:0] VECTOR_STEP     = 16'h0002;
   localparam logic [15:0] STACK_STEP      = 16'h0002;
   localparam logic [15:0] PSW_RESET       = 16'h00e0;
   localparam logic [15:0] PC_RESET        = 16'h0000;
   localparam logic [15:0] SP_RESET        = 16'h1000;
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          POWER_SAVE_MS   = 2;
   localparam int          POWER_SAVE_CYC  = POWER_SAVE_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      PIA_MEM_READ,
      PIA_MEM_WRITE,
      PIA_MEM_RMW
   } pia_mem_op_t;
endpackage

// [rtl/pia_requester.sv]
/*
 Requester end: one device per request line, each with a software enable.
 Raises its line, takes the bus on grant, then runs one direct-memory
 transfer or sends an interrupt command with its vector.
*/
`timescale 1ns/1ps
module pia_requester (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // System bus
   pia_bus_if.dev           bus,
   // User side
   input  wire logic [4:0]  line_enable,
   input  wire logic [4:0]  want,
   input  wire logic [15:0] int_vector [4],
   input  wire logic        dm_write,
   input  wire logic [15:0] dm_addr,
   input  wire logic [15:0] dm_wdata,
   output      logic [15:0] dm_rdata,
   output      logic        done
);
   typedef enum logic [1:0] {IDLE, DM_XFER, INT_SEND} pia_req_state_t;

   pia_req_state_t state, next_state;
   logic [4:0]     pend, next_pend;
   logic [1:0]     lvl, next_lvl;
   logic [15:0]    rdata, next_rdata;
   logic           next_done;

   assign bus.request     = pend;
   assign bus.bus_busy    = (state != IDLE);
   assign bus.intr_cmd    = (state == INT_SEND);
   assign bus.intr_vector = int_vector[lvl];
   assign bus.dm_strobe   = (state == DM_XFER);
   assign bus.dm_write    = dm_write;
   assign bus.dm_addr     = dm_addr;
   assign bus.dm_wdata    = dm_wdata;
   assign dm_rdata        = rdata;

   always_comb begin
      next_state = state;
      // A disabled line drops its pending request as well as refusing new ones.
      next_pend  = (pend | want) & line_enable;
      next_lvl   = lvl;
      next_rdata = rdata;
      next_done  = 1'b0;
      unique case (state)
         IDLE: begin
            if (bus.grant[4]) begin
               next_pend[4] = 1'b0;
               next_state   = DM_XFER;
            end else if (bus.grant[3:0] != 4'h0) begin
               for (int i = 0; i < pia_pkg::NUM_INT_LEVELS; i++) begin
                  if (bus.grant[i]) begin
                     next_lvl     = 2'(i);
                     next_pend[i] = 1'b0;
                  end
               end
               next_state = INT_SEND;
            end
         end
         DM_XFER: begin
            if (bus.dm_ack) begin
               next_rdata = bus.dm_rdata;
               next_done  = 1'b1;
               next_state = IDLE;
            end
         end
         INT_SEND: begin
            if (bus.intr_ack) begin
               next_done  = 1'b1;
               next_state = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= IDLE;
         pend  <= 5'h0;
         lvl   <= 2'h0;
         rdata <= 16'h0;
         done  <= 1'b0;
      end else begin
         state <= next_state;
         pend  <= next_pend;
         lvl   <= next_lvl;
         rdata <= next_rdata;
         done  <= next_done;
      end
   end
endmodule

// [verif/pia_asserts.sv]
/*
 Concurrent checks on the bus between the arbiter and the requester end.
 Assumes it is instantiated beside the interface, fed its signals by name.
*/
`timescale 1ns/1ps
module pia_asserts (
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // System bus
   input wire logic [4:0] request,
   input wire logic [4:0] grant,
   input wire logic       bus_busy,
   input wire logic       intr_cmd,
   input wire logic       intr_ack,
   input wire logic       dm_strobe,
   input wire logic       dm_ack
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_one_master;
      $onehot0(grant);
   endproperty
   a_one_master: assert property (p_one_master) else $error("more than one grant");

   property p_grant_cause;
      (grant != 5'h00 && $past(grant) == 5'h00) |-> ((grant & $past(request)) == grant);
   endproperty
   a_grant_cause: assert property (p_grant_cause) else $error("grant without request");

   property p_dm_first;
      (grant[3:0] != 4'h0 && $past(grant) == 5'h00) |-> !$past(request[4]);
   endproperty
   a_dm_first: assert property (p_dm_first) else $error("interrupt granted over direct memory");

   property p_highest;
      (grant[3:0] != 4'h0 && $past(grant) == 5'h00) |-> ({1'b0, $past(request[3:0])} < {grant[3:0], 1'b0});
   endproperty
   a_highest: assert property (p_highest) else $error("lower level granted first");

   property p_no_grant_busy;
      (grant != 5'h00 && $past(grant) == 5'h00) |-> !$past(bus_busy);
   endproperty
   a_no_grant_busy: assert property (p_no_grant_busy) else $error("grant while bus busy");

   property p_hold_grant;
      (grant != 5'h00 && !bus_busy) |=> (grant == $past(grant));
   endproperty
   a_hold_grant: assert property (p_hold_grant) else $error("grant dropped early");

   property p_release;
      $rose(bus_busy) |=> (grant == 5'h00);
   endproperty
   a_release: assert property (p_release) else $error("grant kept after busy");

   property p_intr_answer;
      $rose(intr_cmd) |-> ##[0:4] intr_ack;
   endproperty
   a_intr_answer: assert property (p_intr_answer) else $error("interrupt command unanswered");

   property p_ack_pulse;
      intr_ack |=> !intr_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("interrupt acknowledge too long");

   property p_dm_answer;
      $rose(dm_strobe) |-> ##[0:8] dm_ack;
   endproperty
   a_dm_answer: assert property (p_dm_answer) else $error("direct memory strobe unanswered");
endmodule

// [verif/priority_interrupt_arbiter_bench.sv]
/*
 Self-checking bench: arbiter and requester joined by the bus interface,
 with a word memory on the arbiter's memory port. Assumes one 100 MHz clock.
*/
`timescale 1ns/1ps
module priority_interrupt_arbiter_bench;
   logic        clk, reset, rmw, rti, psw_write, power_fail, hold, psw_window, done, dm_write;
   logic        mem_strobe, mem_write, mem_ack;
   logic        rti_done, cycle_end, instr_end;
   logic [15:0] psw_wdata, mem_addr, mem_wdata, mem_rdata, pc, psw, sp, dm_addr, dm_wdata, dm_rdata;
   logic [4:0]  line_enable, want;
   logic [15:0] int_vec [4];
   logic [15:0] mem [2048];
   int          mismatches, tests_run, rti_count;

   pia_bus_if bus_if ();
   pia_arbiter pia_arbiter_inst (.clk(clk), .reset(reset), .bus(bus_if), .cpu_bus_cycle_end(cycle_end),
      .cpu_rmw_active(rmw), .cpu_instr_end(instr_end), .cpu_rti(rti), .cpu_psw_write(psw_write),
      .cpu_psw_wdata(psw_wdata), .cpu_hold(hold), .cpu_rti_done(rti_done), .power_fail(power_fail),
      .mem_strobe(mem_strobe), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .program_counter(pc), .processor_status_word(psw),
      .stack_pointer(sp), .power_save_window(psw_window));
   pia_requester pia_requester_inst (.clk(clk), .reset(reset), .bus(bus_if), .line_enable(line_enable),
      .want(want), .int_vector(int_vec), .dm_write(dm_write), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
      .dm_rdata(dm_rdata), .done(done));
   pia_asserts pia_asserts_inst (.clk(clk), .reset(reset), .request(bus_if.request), .grant(bus_if.grant),
      .bus_busy(bus_if.bus_busy), .intr_cmd(bus_if.intr_cmd), .intr_ack(bus_if.intr_ack),
      .dm_strobe(bus_if.dm_strobe), .dm_ack(bus_if.dm_ack));

   // Memory answers in the cycle of the strobe; vectors are loaded during reset.
   assign mem_ack = mem_strobe;
   assign mem_rdata = mem[mem_addr[11:1]];
   always @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            mem[32 + 2 * i] <= 16'(32'h0200 + 32'h0100 * i);
            mem[33 + 2 * i] <= (i == 3) ? 16'h00e0 : 16'h00c0;
         end
         mem[16'h0a] <= 16'h0700;
         mem[16'h0b] <= 16'h00e0;
         mem[16'h80] <= 16'h0000;
      end else if (mem_strobe && mem_write) begin
         mem[mem_addr[11:1]] <= mem_wdata;
      end
   end

   // Counts completed returns so that the return strobe is checked too.
   always @(posedge clk) begin
      if (reset) begin
         rti_count <= 0;
      end else if (rti_done === 1'b1) begin
         rti_count <= rti_count + 1;
      end
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pulse_want(input logic [4:0] w);
      want = w;
      cycles(1);
      want = 5'h00;
   endtask

   task automatic pulse_rti;
      rti = 1'b1;
      cycles(1);
      rti = 1'b0;
   endtask

   // Waits until the processor runs again at the expected address.
   task automatic wait_pc(input logic [15:0] exp_pc, input logic [15:0] exp_psw, input logic [15:0] exp_sp);
      int n;
      n = 0;
      while (!(hold === 1'b0 && pc === exp_pc) && n < 60) begin
         cycles(1);
         n++;
      end
      check(pc, exp_pc);
      check(psw, exp_psw);
      check(sp, exp_sp);
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 60) begin
         cycles(1);
         n++;
      end
      check({15'h0000, done}, 16'h0001);
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      mismatches++;
      final_report();
   end

   initial begin
      {reset, rmw, rti, psw_write, power_fail, dm_write} = 6'h20;
      {cycle_end, instr_end} = 2'h3;
      {psw_wdata, dm_addr, dm_wdata} = 48'h0;
      {line_enable, want} = 10'h3e0;
      {mismatches, tests_run} = 64'h0;
      for (int i = 0; i < 4; i++) begin
         int_vec[i] = 16'(32'h0040 + 4 * i);
      end
      cycles(3);
      reset = 1'b0;
      check(psw, 16'h00e0);
      check(pc, 16'h0000);
      check(sp, 16'h1000);
      pulse_want(5'h08);
      cycles(20);
      check(pc, 16'h0000);
      line_enable = 5'h17;
      cycles(1);
      line_enable = 5'h1f;
      psw_write = 1'b1;
      psw_wdata = 16'h0060;
      cycles(1);
      psw_write = 1'b0;
      cycles(2);
      check(psw, 16'h0060);
      instr_end = 1'b0;
      pulse_want(5'h03);
      cycles(5);
      check(pc, 16'h0000);
      instr_end = 1'b1;
      wait_pc(16'h0300, 16'h00c0, 16'h0ffc);
      check(mem[16'h7ff], 16'h0060);
      check(mem[16'h7fe], 16'h0000);
      cycles(10);
      check(pc, 16'h0300);
      line_enable = 5'h1e;
      pulse_want(5'h08);
      wait_pc(16'h0500, 16'h00e0, 16'h0ff8);
      check(mem[16'h7fd], 16'h00c0);
      check(mem[16'h7fc], 16'h0300);
      pulse_rti();
      wait_pc(16'h0300, 16'h00c0, 16'h0ffc);
      pulse_rti();
      wait_pc(16'h0000, 16'h0060, 16'h1000);
      dm_write = 1'b1;
      dm_addr = 16'h0100;
      dm_wdata = 16'ha5a5;
      rmw = 1'b1;
      pulse_want(5'h10);
      cycles(10);
      check(mem[16'h80], 16'h0000);
      cycle_end = 1'b0;
      rmw = 1'b0;
      cycles(5);
      check(mem[16'h80], 16'h0000);
      cycle_end = 1'b1;
      wait_done();
      check(mem[16'h80], 16'ha5a5);
      check(pc, 16'h0000);
      check(psw, 16'h0060);
      dm_write = 1'b0;
      pulse_want(5'h12);
      wait_done();
      check(dm_rdata, 16'ha5a5);
      wait_pc(16'h0300, 16'h00c0, 16'h0ffc);
      pulse_rti();
      wait_pc(16'h0000, 16'h0060, 16'h1000);
      power_fail = 1'b1;
      wait_pc(16'h0700, 16'h00e0, 16'h0ffc);
      check({15'h0000, psw_window}, 16'h0001);
      pulse_rti();
      wait_pc(16'h0000, 16'h0060, 16'h1000);
      power_fail = 1'b0;
      wait_pc(16'h0700, 16'h00e0, 16'h0ffc);
      check(16'(rti_count), 16'h0004);
      final_report();
   end
endmodule
